//--- src/tpg_pkg.sv
package tpg_pkg;

	// Lane geometry
	localparam int LANES_PER_LINK = 8;
	localparam int LANES_TOTAL    = 16;
	localparam int RAW_W          = 10;

	// Software codes of the test pattern select field
	localparam logic [3:0] SEL_NORMAL    = 4'h0;
	localparam logic [3:0] SEL_PRBS7     = 4'h1;
	localparam logic [3:0] SEL_PRBS15    = 4'h2;
	localparam logic [3:0] SEL_PRBS23    = 4'h3;
	localparam logic [3:0] SEL_RAMP      = 4'h4;
	localparam logic [3:0] SEL_TRANSPORT = 4'h5;
	localparam logic [3:0] SEL_D21_5     = 4'h6;
	localparam logic [3:0] SEL_K28_5     = 4'h7;
	localparam logic [3:0] SEL_ILA_LOOP  = 4'h8;
	localparam logic [3:0] SEL_RPAT      = 4'h9;

	// Decoded pattern modes
	typedef enum logic [3:0] {
		MODE_NORMAL, MODE_PRBS7, MODE_PRBS15, MODE_PRBS23, MODE_RAMP,
		MODE_TRANSPORT, MODE_D21_5, MODE_K28_5, MODE_ILA_LOOP, MODE_RPAT
	} mode_t;

	// PRBS polynomial choice and state width
	typedef enum logic [1:0] {PRBS_SEL_7, PRBS_SEL_15, PRBS_SEL_23} prbs_sel_t;
	localparam int PRBS_STATE_W   = 23;
	localparam int PRBS7_PERIOD   = 127;
	localparam int PRBS15_PERIOD  = 32767;
	localparam int PRBS23_PERIOD  = 8388607;

	// Characters
	localparam logic [7:0] CHAR_D21_5 = 8'hb5;
	localparam logic [7:0] CHAR_K28_5 = 8'hbc;

	// Ramp and short pattern values
	localparam logic [7:0] RAMP_START    = 8'h00;
	localparam logic [7:0] SHORT8_TOP    = 8'hff;
	localparam logic [3:0] SHORT12_TOP   = 4'hf;
	localparam logic [3:0] SHORT12_TAIL  = 4'h0;
	localparam int         SHORT12_OCTETS = 8;
	localparam int         SHORT12_NIBS   = 16;

	// Transport pattern N' values
	localparam logic [4:0] NPRIME_8  = 5'd8;
	localparam logic [4:0] NPRIME_12 = 5'd12;
	localparam logic [4:0] NPRIME_16 = 5'd16;
	localparam int         LONG_TAIL_FRAMES = 2;

	// Modified RPAT octets
	localparam int RPAT_LEN = 12;
	localparam logic [7:0] RPAT_OCTETS [RPAT_LEN] = '{
		8'hbe, 8'hd7, 8'h23, 8'h47, 8'h6b, 8'h8f,
		8'hb3, 8'h14, 8'h5e, 8'hfb, 8'h35, 8'h59
	};
	localparam logic [3:0] RPAT_LAST = 4'hb;

	// Reset values
	localparam logic [7:0]  OCTET_RESET = 8'h00;
	localparam logic [15:0] SAMPLE_RESET = 16'h0000;

endpackage : tpg_pkg

//--- src/prbs_lane.sv
`timescale 1ns/1ns
// Per-lane PRBS source, ten serial bits per step, bit 0 sent first
module prbs_lane
	import tpg_pkg::*;
#(
	parameter logic [PRBS_STATE_W-1:0] SEED = 23'h000001
) (
	input  wire logic             clk,
	input  wire logic             sys_rst,
	input  wire logic             load,
	input  wire logic             step,
	input  wire prbs_sel_t        poly,
	output logic [RAW_W-1:0]      raw_bits_reg
);

	logic [PRBS_STATE_W-1:0] state_reg;
	logic [PRBS_STATE_W-1:0] state_next;
	logic [RAW_W-1:0]        raw_bits_next;
	logic                    fb;

	// Unrolled shift of ten bits, newest bit in position 0
	always_comb begin
		state_next    = state_reg;
		raw_bits_next = '0;
		fb            = 1'b0;
		for (int b = 0; b < RAW_W; b++) begin
			case (poly)
				PRBS_SEL_7:  fb = state_next[5] ^ state_next[6];
				PRBS_SEL_15: fb = state_next[13] ^ state_next[14];
				PRBS_SEL_23: fb = state_next[17] ^ state_next[22];
				default:     fb = state_next[5] ^ state_next[6];
			endcase
			state_next       = {state_next[PRBS_STATE_W-2:0], fb};
			raw_bits_next[b] = fb;
		end
	end

	// Seed differs per lane, so lanes start out of phase
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg    <= SEED;
			raw_bits_reg <= '0;
		end else if (load) begin
			state_reg    <= SEED;
			raw_bits_reg <= '0;
		end else if (step) begin
			state_reg    <= state_next;
			raw_bits_reg <= raw_bits_next;
		end
	end

endmodule : prbs_lane

//--- src/rpat_rom.sv
`timescale 1ns/1ns
// Modified RPAT octet table with registered read
module rpat_rom
	import tpg_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic [3:0] addr,
	output logic [7:0]      data_reg
);

	logic [7:0] data_next;

	// Lookup, out-of-range index gives the first octet
	always_comb begin
		data_next = (addr <= RPAT_LAST) ? RPAT_OCTETS[addr] : RPAT_OCTETS[0];
	end

	// Read register
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			data_reg <= RPAT_OCTETS[0];
		else
			data_reg <= data_next;
	end

endmodule : rpat_rom

//--- src/jesd_tx_test_pattern_gen.sv
`timescale 1ns/1ns
// How it works
// - Select field picks pattern, code 0 and unknown codes normal
// - Lane power follows lane format only
// - PRBS bits bypass the 8b/10b encoder
// - PRBS7 taps six and seven, period 127
// - PRBS15 taps 14,15; PRBS23 taps 18,23
// - Each lane seeds its PRBS differently
// - Ramp: link normal, transport off, formatter dropped
// - Ramp after alignment counts 00 to FF, wraps
// - Short pattern for N' 8/12, long for 16
// - N' 8: lane k sends k, then FF-k
// - N' 12: five words F-i, i, word number
// - Short pattern only on enabled low lanes
// - Long pattern shared, K*ceil((M*S+2)/K) frames
// - Frame 0 index plus one, frame 1 position plus one
// - Converter indices A then B, per link
// - Later frames carry two to N minus one
// - Walking control bit for first M*S frames
// - Long pattern starts after alignment, repeats forever
// - Continuous D21.5 or K28.5 modes
// - Sync request gives CGS then repeated alignment
// - RPAT feeds the twelve fixed octets repeatedly
module jesd_tx_test_pattern_gen
	import tpg_pkg::*;
(
	input  wire logic                       clk,
	input  wire logic                       sys_rst,
	input  wire logic                       link_restart,
	input  wire logic [3:0]                 test_pattern_select,
	input  wire logic [3:0]                 lane_format_config_lanes,
	input  wire logic [4:0]                 lane_format_config_nprime,
	input  wire logic [2:0]                 lane_format_config_m,
	input  wire logic [4:0]                 lane_format_config_s,
	input  wire logic [5:0]                 lane_format_config_k,
	input  wire logic [4:0]                 lane_format_config_n,
	input  wire logic [1:0]                 lane_format_config_cs,
	input  wire logic                       octet_tick,
	input  wire logic                       ilas_done,
	input  wire logic                       sync_request,
	input  wire logic [8*LANES_TOTAL-1:0]   link_octets_in,
	input  wire logic [LANES_TOTAL-1:0]     link_is_k_in,
	output logic [8*LANES_PER_LINK-1:0]     link_a_lane_octets_reg,
	output logic [LANES_PER_LINK-1:0]       link_a_lane_is_k_reg,
	output logic [8*LANES_PER_LINK-1:0]     link_b_lane_octets_reg,
	output logic [LANES_PER_LINK-1:0]       link_b_lane_is_k_reg,
	output logic [RAW_W*LANES_TOTAL-1:0]    lane_raw_bits_reg,
	output logic                            encoder_bypass_reg,
	output logic [LANES_TOTAL-1:0]          lane_power_en_reg,
	output logic                            transport_enable_reg,
	output logic                            formatter_discard_reg,
	output logic                            ilas_repeat_reg,
	output logic                            cgs_start_reg,
	output logic                            long_valid_reg,
	output logic [15:0]                     long_sample_reg,
	output logic                            long_ctrl_reg,
	output logic [2:0]                      long_converter_index_reg,
	output logic [4:0]                      long_sample_position_index_reg
);

	mode_t       mode_reg;
	mode_t       mode_next;
	prbs_sel_t   poly;
	logic        is_prbs;
	logic        long_mode;
	logic        short_mode;
	logic        data_step;
	logic [7:0]  ramp_reg;
	logic        short8_frame_reg;
	logic [2:0]  short12_oct_reg;
	logic [3:0]  rpat_idx_reg;
	logic [7:0]  rpat_octet;
	logic        sync_request_d_reg;
	logic [4:0]  sid_reg;
	logic [2:0]  cid_reg;
	logic [7:0]  frame_reg;
	logic [5:0]  mf_reg;
	logic [7:0]  ms_product;
	logic        last_sample;
	logic        pattern_end;
	logic [15:0] sample_next;
	logic        ctrl_next;
	logic [7:0]  flat_index;

	// Nibble j of lane i in the N'=12 short frame
	function automatic logic [3:0] short12_nib(input logic [3:0] lane_i, input logic [4:0] j);
		logic [4:0] w;
		logic [4:0] p;
		w = 5'(j / 5'd3);
		p = 5'(j % 5'd3);
		if (j == 5'(SHORT12_NIBS - 1))
			short12_nib = SHORT12_TAIL;
		else if (p == 5'd0)
			short12_nib = SHORT12_TOP - lane_i;
		else if (p == 5'd1)
			short12_nib = lane_i;
		else
			short12_nib = 4'(w + 5'd1);
	endfunction : short12_nib

	// Select field decode, unknown codes fall back to normal data
	always_comb begin
		case (test_pattern_select)
			SEL_PRBS7:     mode_next = MODE_PRBS7;
			SEL_PRBS15:    mode_next = MODE_PRBS15;
			SEL_PRBS23:    mode_next = MODE_PRBS23;
			SEL_RAMP:      mode_next = MODE_RAMP;
			SEL_TRANSPORT: mode_next = MODE_TRANSPORT;
			SEL_D21_5:     mode_next = MODE_D21_5;
			SEL_K28_5:     mode_next = MODE_K28_5;
			SEL_ILA_LOOP:  mode_next = MODE_ILA_LOOP;
			SEL_RPAT:      mode_next = MODE_RPAT;
			default:       mode_next = MODE_NORMAL;
		endcase
	end

	// Mode is taken while the link restarts; software keeps it stable otherwise
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			mode_reg <= MODE_NORMAL;
		else if (link_restart)
			mode_reg <= mode_next;
	end

	// Mode helpers
	always_comb begin
		is_prbs    = (mode_reg == MODE_PRBS7) || (mode_reg == MODE_PRBS15) || (mode_reg == MODE_PRBS23);
		case (mode_reg)
			MODE_PRBS15: poly = PRBS_SEL_15;
			MODE_PRBS23: poly = PRBS_SEL_23;
			default:     poly = PRBS_SEL_7;
		endcase
		long_mode  = (mode_reg == MODE_TRANSPORT) && (lane_format_config_nprime == NPRIME_16);
		short_mode = (mode_reg == MODE_TRANSPORT) &&
			((lane_format_config_nprime == NPRIME_8) || (lane_format_config_nprime == NPRIME_12));
		data_step  = octet_tick && ilas_done && !link_restart;
	end

	// Shared ramp counter, wraps naturally at FF
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			ramp_reg <= RAMP_START;
		else if (link_restart || !ilas_done)
			ramp_reg <= RAMP_START;
		else if (octet_tick)
			ramp_reg <= ramp_reg + 8'h01;
	end

	// Short pattern frame and octet position
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			short8_frame_reg <= 1'b0;
			short12_oct_reg  <= 3'd0;
		end else if (link_restart || !ilas_done) begin
			short8_frame_reg <= 1'b0;
			short12_oct_reg  <= 3'd0;
		end else if (octet_tick) begin
			short8_frame_reg <= ~short8_frame_reg;
			short12_oct_reg  <= short12_oct_reg + 3'd1;
		end
	end

	// RPAT index, runs continuously in its mode
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			rpat_idx_reg <= 4'd0;
		else if (link_restart || mode_reg != MODE_RPAT)
			rpat_idx_reg <= 4'd0;
		else if (octet_tick)
			rpat_idx_reg <= (rpat_idx_reg == RPAT_LAST) ? 4'd0 : rpat_idx_reg + 4'd1;
	end

	rpat_rom u_rpat_rom (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.addr     (rpat_idx_reg),
		.data_reg (rpat_octet)
	);

	// Sync request edge starts code group sync in repeated-alignment mode
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sync_request_d_reg <= 1'b0;
			cgs_start_reg      <= 1'b0;
			ilas_repeat_reg    <= 1'b0;
		end else begin
			sync_request_d_reg <= sync_request;
			cgs_start_reg      <= (mode_reg == MODE_ILA_LOOP) && sync_request && !sync_request_d_reg;
			ilas_repeat_reg    <= (mode_reg == MODE_ILA_LOOP);
		end
	end

	// Long pattern walk position
	always_comb begin
		ms_product  = 8'(lane_format_config_m * lane_format_config_s);
		last_sample = (sid_reg == lane_format_config_s - 5'd1) && (cid_reg == lane_format_config_m - 3'd1);
		pattern_end = ((frame_reg + 8'd1) >= (ms_product + 8'(LONG_TAIL_FRAMES))) &&
			(mf_reg == lane_format_config_k - 6'd1);
		flat_index  = 8'(cid_reg * lane_format_config_s) + 8'(sid_reg);
	end

	// Samples walk by position, then converter, then frame
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sid_reg   <= 5'd0;
			cid_reg   <= 3'd0;
			frame_reg <= 8'd0;
			mf_reg    <= 6'd0;
		end else if (!long_mode || link_restart || !ilas_done) begin
			sid_reg   <= 5'd0;
			cid_reg   <= 3'd0;
			frame_reg <= 8'd0;
			mf_reg    <= 6'd0;
		end else if (data_step) begin
			if (sid_reg != lane_format_config_s - 5'd1)
				sid_reg <= sid_reg + 5'd1;
			else begin
				sid_reg <= 5'd0;
				cid_reg <= (cid_reg == lane_format_config_m - 3'd1) ? 3'd0 : cid_reg + 3'd1;
			end
			if (last_sample) begin
				frame_reg <= pattern_end ? 8'd0 : frame_reg + 8'd1;
				mf_reg    <= (pattern_end || mf_reg == lane_format_config_k - 6'd1) ? 6'd0 : mf_reg + 6'd1;
			end
		end
	end

	// Sample value and walking control bit
	always_comb begin
		if (frame_reg == 8'd0)
			sample_next = 16'(cid_reg) + 16'd1;
		else if (frame_reg == 8'd1)
			sample_next = 16'(sid_reg) + 16'd1;
		else
			sample_next = 16'(16'd1 << (lane_format_config_n - 5'd1));
		ctrl_next = (lane_format_config_cs != 2'd0) && (frame_reg < ms_product) &&
			(flat_index == frame_reg);
	end

	// Long pattern feed toward the transport layer of both links
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			long_valid_reg                 <= 1'b0;
			long_sample_reg                <= SAMPLE_RESET;
			long_ctrl_reg                  <= 1'b0;
			long_converter_index_reg       <= 3'd0;
			long_sample_position_index_reg <= 5'd0;
		end else begin
			long_valid_reg                 <= long_mode && data_step;
			long_sample_reg                <= sample_next;
			long_ctrl_reg                  <= ctrl_next;
			long_converter_index_reg       <= cid_reg;
			long_sample_position_index_reg <= sid_reg;
		end
	end

	// Path controls toward the link and transport layers
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			transport_enable_reg  <= 1'b1;
			formatter_discard_reg <= 1'b0;
			encoder_bypass_reg    <= 1'b0;
		end else begin
			transport_enable_reg  <= (mode_reg != MODE_RAMP);
			formatter_discard_reg <= (mode_reg == MODE_RAMP) || long_mode;
			encoder_bypass_reg    <= is_prbs;
		end
	end

	genvar g;
	generate
		for (g = 0; g < LANES_TOTAL; g++) begin : gen_lane
			localparam logic [3:0] LANE_I = 4'(g % LANES_PER_LINK);
			logic [7:0]       octet_next;
			logic             is_k_next;
			logic             enabled;
			logic [RAW_W-1:0] prbs_bits;
			logic [7:0]       short_octet;

			prbs_lane #(
				.SEED (PRBS_STATE_W'(g + 1))
			) u_prbs (
				.clk          (clk),
				.sys_rst      (sys_rst),
				.load         (link_restart || !is_prbs),
				.step         (octet_tick && is_prbs),
				.poly         (poly),
				.raw_bits_reg (prbs_bits)
			);

			// Short transport octet of this lane
			always_comb begin
				enabled = ({1'b0, LANE_I} < {1'b0, lane_format_config_lanes});
				if (lane_format_config_nprime == NPRIME_8)
					short_octet = short8_frame_reg ? (SHORT8_TOP - 8'(LANE_I)) : 8'(LANE_I);
				else
					short_octet = {short12_nib(LANE_I, {short12_oct_reg, 2'b00} >> 1),
						short12_nib(LANE_I, ({short12_oct_reg, 2'b00} >> 1) + 5'd1)};
			end

			// Octet to the encoder for this lane
			always_comb begin
				octet_next = link_octets_in[8*g +: 8];
				is_k_next  = link_is_k_in[g];
				case (mode_reg)
					MODE_RAMP: begin
						if (ilas_done) begin
							octet_next = ramp_reg;
							is_k_next  = 1'b0;
						end
					end
					MODE_TRANSPORT: begin
						if (short_mode && ilas_done) begin
							octet_next = enabled ? short_octet : OCTET_RESET;
							is_k_next  = 1'b0;
						end
					end
					MODE_D21_5: begin
						octet_next = CHAR_D21_5;
						is_k_next  = 1'b0;
					end
					MODE_K28_5: begin
						octet_next = CHAR_K28_5;
						is_k_next  = 1'b1;
					end
					MODE_RPAT: begin
						octet_next = rpat_octet;
						is_k_next  = 1'b0;
					end
					default: begin
						octet_next = link_octets_in[8*g +: 8];
						is_k_next  = link_is_k_in[g];
					end
				endcase
			end

			// Lane output registers and power, power from lane count only
			always_ff @(posedge clk or posedge sys_rst) begin
				if (sys_rst) begin
					lane_power_en_reg[g]              <= 1'b0;
					lane_raw_bits_reg[RAW_W*g +: RAW_W] <= '0;
				end else begin
					lane_power_en_reg[g]              <= enabled;
					lane_raw_bits_reg[RAW_W*g +: RAW_W] <= is_prbs ? prbs_bits : '0;
				end
			end

			if (g < LANES_PER_LINK) begin : gen_a
				always_ff @(posedge clk or posedge sys_rst) begin
					if (sys_rst) begin
						link_a_lane_octets_reg[8*g +: 8] <= OCTET_RESET;
						link_a_lane_is_k_reg[g]          <= 1'b0;
					end else begin
						link_a_lane_octets_reg[8*g +: 8] <= octet_next;
						link_a_lane_is_k_reg[g]          <= is_k_next;
					end
				end
			end else begin : gen_b
				always_ff @(posedge clk or posedge sys_rst) begin
					if (sys_rst) begin
						link_b_lane_octets_reg[8*(g-LANES_PER_LINK) +: 8] <= OCTET_RESET;
						link_b_lane_is_k_reg[g-LANES_PER_LINK]          <= 1'b0;
					end else begin
						link_b_lane_octets_reg[8*(g-LANES_PER_LINK) +: 8] <= octet_next;
						link_b_lane_is_k_reg[g-LANES_PER_LINK]          <= is_k_next;
					end
				end
			end
		end
	endgenerate

endmodule : jesd_tx_test_pattern_gen

//--- verification/tpg_assertions.sv
`timescale 1ns/1ns
// Port-level checks of the pattern generator
module tpg_checker
	import tpg_pkg::*;
(
	input wire logic                         clk,
	input wire logic                         sys_rst,
	input wire logic                         link_restart,
	input wire logic [3:0]                   lane_format_config_lanes,
	input wire logic [2:0]                   lane_format_config_m,
	input wire logic [4:0]                   lane_format_config_s,
	input wire logic                         octet_tick,
	input wire logic                         sync_request,
	input wire logic [RAW_W*LANES_TOTAL-1:0] lane_raw_bits_reg,
	input wire logic                         encoder_bypass_reg,
	input wire logic [LANES_TOTAL-1:0]       lane_power_en_reg,
	input wire logic                         transport_enable_reg,
	input wire logic                         formatter_discard_reg,
	input wire logic                         ilas_repeat_reg,
	input wire logic                         cgs_start_reg,
	input wire logic                         long_valid_reg,
	input wire logic [2:0]                   long_converter_index_reg,
	input wire logic [4:0]                   long_sample_position_index_reg
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	logic [7:0] pwr_mask;

	// Lanes powered on each link by the lane format
	always_comb pwr_mask = 8'((9'h1 << lane_format_config_lanes) - 9'h1);

	a_power_follow: assert property (!$past(sys_rst) |-> lane_power_en_reg == {2{$past(pwr_mask)}})
		else $error("lane power differs from lane format");
	a_raw_quiet: assert property (
		!encoder_bypass_reg && !link_restart && !$past(link_restart) |-> lane_raw_bits_reg == '0)
		else $error("raw lane bits outside bypass");
	a_cgs_single: assert property (cgs_start_reg |=> !cgs_start_reg)
		else $error("sync start longer than one cycle");
	a_cgs_cause: assert property (
		cgs_start_reg |-> ilas_repeat_reg && $past(sync_request) && !$past(sync_request, 2))
		else $error("sync start without a new request");
	a_ramp_discard: assert property (!transport_enable_reg |-> formatter_discard_reg && !encoder_bypass_reg)
		else $error("transport off without discard");
	a_prbs_alone: assert property (
		encoder_bypass_reg |-> transport_enable_reg && !ilas_repeat_reg && !formatter_discard_reg)
		else $error("bypass mixed with another mode");
	a_long_answer: assert property (long_valid_reg |-> $past(octet_tick) && formatter_discard_reg)
		else $error("long sample without a tick");
	a_long_index: assert property (
		long_valid_reg |-> long_converter_index_reg < lane_format_config_m
		&& long_sample_position_index_reg < lane_format_config_s)
		else $error("long sample index out of range");
	a_mode_hold: assert property (
		!link_restart && !$past(link_restart) && !$past(link_restart, 2) |-> $stable(encoder_bypass_reg)
		&& $stable(ilas_repeat_reg) && $stable(transport_enable_reg))
		else $error("mode moved without a restart");
endmodule : tpg_checker

bind jesd_tx_test_pattern_gen tpg_checker chk_u (
	.clk(clk), .sys_rst(sys_rst), .link_restart(link_restart), .octet_tick(octet_tick),
	.lane_format_config_lanes(lane_format_config_lanes), .lane_format_config_m(lane_format_config_m),
	.lane_format_config_s(lane_format_config_s), .sync_request(sync_request),
	.lane_raw_bits_reg(lane_raw_bits_reg), .encoder_bypass_reg(encoder_bypass_reg),
	.lane_power_en_reg(lane_power_en_reg), .transport_enable_reg(transport_enable_reg),
	.formatter_discard_reg(formatter_discard_reg), .ilas_repeat_reg(ilas_repeat_reg),
	.cgs_start_reg(cgs_start_reg), .long_valid_reg(long_valid_reg),
	.long_converter_index_reg(long_converter_index_reg),
	.long_sample_position_index_reg(long_sample_position_index_reg)
);

//--- verification/rx_model.sv
`timescale 1ns/1ns
// Receiver stand-in: raises a sync request on command
module rx_model (
	input  wire logic clk,
	input  wire logic sys_rst,
	input  wire logic req,
	input  wire logic slow,
	output logic      sync_request
);
	int hold_cnt;

	// Request held a short or a long while, then dropped
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			hold_cnt <= 0;
			sync_request <= 1'b0;
		end else if (req) begin
			hold_cnt <= slow ? 12 : 3;
			sync_request <= 1'b1;
		end else if (hold_cnt > 1) begin
			hold_cnt <= hold_cnt - 1;
		end else begin
			hold_cnt <= 0;
			sync_request <= 1'b0;
		end
	end
endmodule : rx_model

//--- verification/tb.sv
`timescale 1ns/1ns
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fails++; $display("Error %0t: %0h vs %0h", $time, a, b); end end
// Self-checking bench for the test pattern generator
module tb;
	import tpg_pkg::*;
	logic         clk = 1'b0, sys_rst = 1'b1, link_restart = 1'b0, octet_tick = 1'b0;
	logic         ilas_done = 1'b0, sync_go = 1'b0, slow = 1'b0, got, lc, lv;
	logic         bypass, tp_en, discard, ila_rep, cgs, sync_request;
	logic [3:0]   test_pattern_select = 4'h0, lanes = 4'h8;
	logic [4:0]   nprime = 5'd12, s = 5'd1, n = 5'd12, lsid;
	logic [2:0]   m = 3'd2, lcid;
	logic [5:0]   k = 6'd3;
	logic [1:0]   cs = 2'd1;
	logic [7:0]   a_k, b_k;
	logic [15:0]  link_is_k_in = '0, pwr, ls, exp8;
	logic [63:0]  a_oct, b_oct, lw;
	logic [127:0] link_octets_in = '0;
	logic [159:0] raw;
	logic [31:0]  seed = 32'h4343;
	logic [24:0]  lq[$];
	logic         bq[$];
	logic [7:0]   rtab[12] = '{8'hbe, 8'hd7, 8'h23, 8'h47, 8'h6b, 8'h8f, 8'hb3, 8'h14, 8'h5e, 8'hfb, 8'h35, 8'h59};
	int           tap1[3] = '{6, 14, 18};
	int           tap2[3] = '{7, 15, 23};
	int           fails = 0, compares = 0, flen, sp, guard, f, c, sd, ev;

	// Device under test and receiver stand-in
	jesd_tx_test_pattern_gen dut_u (
		.clk, .sys_rst, .link_restart, .test_pattern_select,
		.lane_format_config_lanes(lanes), .lane_format_config_nprime(nprime), .lane_format_config_m(m),
		.lane_format_config_s(s), .lane_format_config_k(k), .lane_format_config_n(n),
		.lane_format_config_cs(cs), .octet_tick, .ilas_done, .sync_request, .link_octets_in, .link_is_k_in,
		.link_a_lane_octets_reg(a_oct), .link_a_lane_is_k_reg(a_k), .link_b_lane_octets_reg(b_oct),
		.link_b_lane_is_k_reg(b_k), .lane_raw_bits_reg(raw), .encoder_bypass_reg(bypass),
		.lane_power_en_reg(pwr), .transport_enable_reg(tp_en), .formatter_discard_reg(discard),
		.ilas_repeat_reg(ila_rep), .cgs_start_reg(cgs), .long_valid_reg(lv), .long_sample_reg(ls),
		.long_ctrl_reg(lc), .long_converter_index_reg(lcid), .long_sample_position_index_reg(lsid)
	);
	rx_model rx_u (.clk, .sys_rst, .req(sync_go), .slow, .sync_request);

	always #25 clk = ~clk;

	// Long pattern samples as they leave
	always @(negedge clk) begin
		if (lv === 1'b1) begin
			lq.push_back({ls, lc, lcid, lsid});
		end
	end

	// Cut a hang short
	initial begin
		repeat (30000) @(posedge clk);
		fails++;
		end_of_test();
	end

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	task automatic restart(input logic [3:0] code);
		test_pattern_select = code;
		ilas_done = 1'b0;
		link_restart = 1'b1;
		@(negedge clk);
		link_restart = 1'b0;
		@(negedge clk);
	endtask : restart

	task automatic ticks(input int cnt, input int gap);
		octet_tick = 1'b1;
		repeat (cnt) @(negedge clk);
		octet_tick = 1'b0;
		repeat (gap) @(negedge clk);
	endtask : ticks

	task automatic end_of_test();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : end_of_test

	// Main sequence
	initial begin
		repeat (20) @(negedge clk);
		sys_rst = 1'b0;
		@(negedge clk);
		`CHK({tp_en, bypass, discard}, 3'b100)
		for (int i = 10; i <= 16; i++) begin
			restart(4'(i));
			repeat (3) begin
				link_octets_in = {rnd(), rnd(), rnd(), rnd()};
				link_is_k_in = 16'(rnd());
				@(negedge clk);
				`CHK({b_oct, a_oct}, link_octets_in)
				`CHK({b_k, a_k}, link_is_k_in)
			end
		end
		$display("done: normal data");
		restart(SEL_RAMP);
		test_pattern_select = SEL_PRBS7;
		ilas_done = 1'b1;
		`CHK({tp_en, discard}, 2'b01)
		@(negedge clk);
		for (int i = 0; i < 260; i++) begin
			`CHK({b_oct, a_oct}, {16{8'(i)}})
			ticks(1, 2);
		end
		`CHK(bypass, 1'b0)
		$display("done: ramp");
		for (int p = 0; p < 3; p++) begin
			restart(SEL_PRBS7 + 4'(p));
			bq.delete();
			for (int w = 0; w < 6; w++) begin
				ticks(1, 2);
				`CHK(bypass, 1'b1)
				for (int b = 0; b < 10; b++) begin
					bq.push_back(raw[b]);
				end
			end
			`CHK(raw[9:0] != raw[19:10] && raw[9:0] != raw[159:150], 1'b1)
			for (int j = tap2[p]; j < 60; j++) begin
				`CHK(bq[j], bq[j - tap1[p]] ^ bq[j - tap2[p]])
			end
		end
		$display("done: prbs");
		lanes = 4'h2;
		nprime = 5'd8;
		restart(SEL_TRANSPORT);
		ilas_done = 1'b1;
		`CHK(pwr, 16'h0303)
		for (int i = 0; i < 4; i++) begin
			ticks(1, 2);
			exp8 = i[0] ? 16'h0100 : 16'hfeff;
			`CHK({b_oct, a_oct}, {48'h0, exp8, 48'h0, exp8})
			`CHK(discard, 1'b0)
		end
		// Twelve-bit short frame: five words then a zero tail
		nprime = 5'd12;
		restart(SEL_TRANSPORT);
		ilas_done = 1'b1;
		for (int i = 1; i <= 8; i++) begin
			ticks(1, 2);
			for (int l = 0; l < 2; l++) begin
				lw = '0;
				for (int w = 1; w <= 5; w++) begin
					lw = {lw[51:0], 4'hf - 4'(l), 4'(l), 4'(w)};
				end
				exp8[8*l +: 8] = 8'({lw[59:0], 4'h0} >> (8 * (7 - i % 8)));
			end
			`CHK({b_oct[15:0], a_oct[15:0]}, {exp8, exp8})
		end
		$display("done: short pattern");
		lanes = 4'h8;
		for (int i = 0; i < 2; i++) begin
			restart(i ? SEL_K28_5 : SEL_D21_5);
			ticks(1, 2);
			`CHK({b_oct, a_oct}, {16{i ? 8'hbc : 8'hb5}})
			`CHK({b_k, a_k}, {16{i[0]}})
		end
		restart(SEL_RPAT);
		for (int i = 0; i < 14; i++) begin
			ticks(1, 2);
			`CHK({b_oct, a_oct}, {16{rtab[(i + 1) % 12]}})
		end
		$display("done: characters");
		restart(SEL_ILA_LOOP);
		`CHK(ila_rep, 1'b1)
		for (int i = 0; i < 2; i++) begin
			slow = i[0];
			sync_go = 1'b1;
			@(negedge clk);
			sync_go = 1'b0;
			got = 1'b0;
			repeat (8) begin
				@(negedge clk);
				got = got | cgs;
			end
			`CHK(got, 1'b1)
			repeat (14) @(negedge clk);
		end
		$display("done: repeated alignment");
		nprime = 5'd16;
		restart(SEL_TRANSPORT);
		ticks(3, 1);
		`CHK(lq.size(), 0)
		ilas_done = 1'b1;
		sp = m * s;
		flen = k * ((sp + 2 + k - 1) / k);
		guard = 0;
		while (lq.size() < 2 * flen * sp && guard < 200) begin
			ticks(1 + rnd() % 3, 1 + rnd() % 2);
			guard++;
		end
		if (guard == 200) begin
			fails++;
			end_of_test();
		end
		for (int i = 0; i < 2 * flen * sp; i++) begin
			f = (i / sp) % flen;
			c = (i % sp) / s;
			sd = i % s;
			ev = (f == 0) ? c + 1 : (f == 1) ? sd + 1 : 1 << (n - 1);
			`CHK(lq[i], {16'(ev), f < sp && f == i % sp, 3'(c), 5'(sd)})
		end
		$display("done: long pattern");
		end_of_test();
	end
endmodule : tb
